// ===== wdt_pkg.sv
// Purpose: Shared constants and types for the watchdog reset timer.
// Assumes: 32-bit AXI4-Lite register access, one core clock of 50 MHz.
// Notes: Every offset, field position, reset value and count is defined here; the assertions repeat the 4- and 8-cycle counts as literals.
package wdt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RESTART = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h00C;

  // Control register fields
  localparam int BIT_TURN_OFF_ENABLE = 4;
  localparam int BIT_WATCHDOG_ENABLE = 3;
  localparam int BIT_SEL_HI = 2;
  localparam int BIT_SEL_LO = 0;
  localparam int CONTROL_W = 8;

  // Status and restart register fields
  localparam int BIT_RESET_SEEN = 0;
  localparam int BIT_RESET_ACTIVE = 1;
  localparam int BIT_RESTART = 0;

  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [2:0] RST_SEL = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int TOE_CLEAR_CYCLES = 4;     // Core cycles the turn-off window stays open
  localparam int CHIP_RST_CYCLES = 8;      // Core cycles the chip reset is held
  localparam int BASE_OSC_CYCLES = 16384;  // Shortest time-out, oscillator cycles
  localparam int CNT_W = 21;               // Holds the longest time-out minus one
  localparam int TOE_CNT_W = 3;
  localparam int HOLD_CNT_W = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic turn_off_enable;
    logic watchdog_enable;
    logic [2:0] timeout_select;
  } wdt_ctrl_t;

  typedef struct packed {
    logic timeout;
    logic [CNT_W-1:0] count;
  } wdt_cnt_state_t;

endpackage : wdt_pkg

// ===== wdt_osc_counter.sv
// Purpose: Counts watchdog oscillator cycles and flags the selected time-out.
// Assumes: The oscillator arrives as a slow level sampled on the core clock.
// Notes: The oscillator must run well below half the core clock rate.
`timescale 1ns/10ps
`default_nettype none
module wdt_osc_counter #(
  parameter int BASE_CYCLES = wdt_pkg::BASE_OSC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wdt_osc,
  input wire logic enable,
  input wire logic restart,
  input wire logic [2:0] timeout_select,
  output wdt_pkg::wdt_cnt_state_t state
);

  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;
  logic [wdt_pkg::CNT_W-1:0] count;
  logic [wdt_pkg::CNT_W-1:0] limit;
  logic [31:0] limit_wide;

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= wdt_osc;  // [RL14]
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign osc_edge = osc_sync & ~osc_prev;  // [RL1]

  // Terminal count doubles with each select code
  assign limit_wide = (BASE_CYCLES << timeout_select) - 1;  // [RL11]
  assign limit = limit_wide[wdt_pkg::CNT_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Counter holds while disabled, so a later enable may not start at zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;  // [RL2]
    end else if (enable && osc_edge) begin
      if (count >= limit) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;  // [RL12]
      end
    end
  end

  assign state.count = count;
  assign state.timeout = enable && osc_edge && !restart && (count >= limit);  // [RL6]

endmodule : wdt_osc_counter
`default_nettype wire

// ===== wdt_watchdog_reset_timer.sv
// Purpose: Watchdog reset timer with an AXI4-Lite register port.
// Assumes: Synchronous active-low reset; oscillator input sampled on core_clk.
// Notes: The chip reset output should be routed back to the system reset.
//
// How it works
// RL1: The counter advances only on edges of the separate watchdog oscillator.
// RL2: A restart clears the counter so a fresh period begins.
// RL3: When the selected period runs out while enabled, a chip reset is raised.
// RL4: Control holds turn-off enable at bit 4, enable at bit 3, select at bits 2..0.
// RL5: Control bits 7..5 ignore writes and read as zero.
// RL6: With enable set the watchdog runs; with it clear no reset is produced.
// RL7: Clearing enable succeeds only while turn-off enable is set.
// RL8: Hardware clears turn-off enable four clock cycles after it was set.
// RL9: Software opens the turn-off window by writing ones to both flags at once.
// RL10: Software then writes enable zero within four cycles to disable.
// RL11: Select codes 0 to 7 give 16K doubling up to 2048K oscillator cycles.
// RL12: The select only governs the period while the watchdog is enabled.
// RL13: Software should restart before enabling so the first period is full.
// RL14: The oscillator is brought into the core domain through a synchroniser.
`timescale 1ns/10ps
`default_nettype none
module wdt_watchdog_reset_timer #(
  parameter int BASE_CYCLES = wdt_pkg::BASE_OSC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wdt_osc,
  input wire logic watchdog_restart_instr,
  output logic chip_reset,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wdt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  wdt_pkg::wdt_ctrl_t ctrl;
  wdt_pkg::wdt_cnt_state_t cnt_state;
  logic [wdt_pkg::TOE_CNT_W-1:0] toe_cnt;
  logic [wdt_pkg::HOLD_CNT_W-1:0] hold_cnt;
  logic reset_seen;
  logic aw_held;
  logic w_held;
  logic [wdt_pkg::ADDR_W-1:0] aw_addr_q;
  logic [wdt_pkg::DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [wdt_pkg::ADDR_W-1:0] wr_addr;
  logic [wdt_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_status;
  logic wr_restart;
  logic wr_hit;
  logic restart_any;
  logic next_enable;
  logic [wdt_pkg::DATA_W-1:0] next_rdata;
  logic next_rhit;
  logic enable_q;
  logic [2:0] select_q;
  logic toe_load;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel acceptance; address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign do_write = (aw_held || aw_fire) && (w_held || w_fire);
  assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held ? w_strb_q : s_axi_wstrb;
  assign wr_lane0 = do_write && wr_strb[0];

  // Word decode ignores the two byte-offset bits
  assign wr_ctrl = wr_lane0 && (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_CONTROL[11:2]);
  assign wr_status = wr_lane0 && (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_STATUS[11:2]);
  assign wr_restart = wr_lane0 && (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_RESTART[11:2]);
  assign wr_hit = (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_CONTROL[11:2])
      || (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_STATUS[11:2])
      || (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_RESTART[11:2])
      || (wr_addr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_COUNT[11:2]);

  // Hold whichever half came first until its partner arrives
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdt_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable may rise freely but falls only inside the turn-off window
  always_comb begin
    next_enable = ctrl.watchdog_enable;
    if (wr_ctrl) begin
      if (wr_data[wdt_pkg::BIT_WATCHDOG_ENABLE]) begin
        next_enable = 1'b1;
      end else if (ctrl.turn_off_enable) begin
        next_enable = 1'b0;  // [RL7]
      end
    end
  end

  // Control fields; the reserved upper bits have no storage at all
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_q <= wdt_pkg::RST_ENABLE;
      select_q <= wdt_pkg::RST_SEL;
    end else begin
      enable_q <= next_enable;  // [RL6]
      if (wr_ctrl) begin
        select_q <= wr_data[wdt_pkg::BIT_SEL_HI:wdt_pkg::BIT_SEL_LO];  // [RL4]
      end
    end
  end

  // A write with the turn-off bit set opens or reopens the window
  assign toe_load = wr_ctrl && wr_data[wdt_pkg::BIT_TURN_OFF_ENABLE];

  // Turn-off window: a set reloads the countdown, hardware alone clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      toe_cnt <= '0;
    end else if (toe_load) begin
      toe_cnt <= wdt_pkg::TOE_CNT_W'(wdt_pkg::TOE_CLEAR_CYCLES);  // [RL8]
    end else if (toe_cnt != '0) begin
      toe_cnt <= toe_cnt - 1'b1;
    end
  end

  // One driver for the whole carrier; the turn-off flag is the live countdown
  assign ctrl = '{
    turn_off_enable: (toe_cnt != '0),
    watchdog_enable: enable_q,
    timeout_select: select_q
  };

  //////////////////////////////////////////////////////////////////////////////
  // Restart comes from the core's instruction, from a register write or from the chip reset itself
  assign restart_any = watchdog_restart_instr
      || (wr_restart && wr_data[wdt_pkg::BIT_RESTART])
      || chip_reset;  // [RL2]

  wdt_osc_counter #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_counter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wdt_osc(wdt_osc),
    .enable(ctrl.watchdog_enable),
    .restart(restart_any),
    .timeout_select(ctrl.timeout_select),
    .state(cnt_state)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Chip reset is stretched so slow reset logic downstream sees it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_cnt <= '0;
    end else if (cnt_state.timeout) begin
      hold_cnt <= wdt_pkg::HOLD_CNT_W'(wdt_pkg::CHIP_RST_CYCLES);  // [RL3]
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end
  end

  assign chip_reset = (hold_cnt != '0);

  // Sticky record of a time-out; a new time-out beats a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_seen <= 1'b0;
    end else if (cnt_state.timeout) begin
      reset_seen <= 1'b1;
    end else if (wr_status && wr_data[wdt_pkg::BIT_RESET_SEEN]) begin
      reset_seen <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    next_rdata = '0;
    next_rhit = 1'b1;
    unique case (s_axi_araddr[wdt_pkg::ADDR_W-1:2])
      wdt_pkg::OFF_CONTROL[11:2]: begin
        next_rdata[wdt_pkg::BIT_TURN_OFF_ENABLE] = ctrl.turn_off_enable;
        next_rdata[wdt_pkg::BIT_WATCHDOG_ENABLE] = ctrl.watchdog_enable;
        next_rdata[wdt_pkg::BIT_SEL_HI:wdt_pkg::BIT_SEL_LO] = ctrl.timeout_select;  // [RL5]
      end
      wdt_pkg::OFF_STATUS[11:2]: begin
        next_rdata[wdt_pkg::BIT_RESET_SEEN] = reset_seen;
        next_rdata[wdt_pkg::BIT_RESET_ACTIVE] = chip_reset;
      end
      wdt_pkg::OFF_RESTART[11:2]: begin
        next_rdata = '0;
      end
      wdt_pkg::OFF_COUNT[11:2]: begin
        next_rdata[wdt_pkg::CNT_W-1:0] = cnt_state.count;
      end
      default: begin
        next_rhit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // Read data is registered and held until the master takes it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= wdt_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rhit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // A reload inside the window legitimately stretches it
  chk_toe_set: assert property ( // [RL8]
    toe_load |=> ctrl.turn_off_enable [*4]
      ##1 (!ctrl.turn_off_enable || $past(toe_load) || $past(toe_load, 2)
      || $past(toe_load, 3) || $past(toe_load, 4))
  ) else $error("turn-off enable did not last exactly four cycles");

  chk_toe_clear: assert property ( // [RL8]
    (toe_cnt == 3'h1 && !wr_ctrl) |=> !ctrl.turn_off_enable
  ) else $error("turn-off enable not cleared by hardware");

  chk_enable_guard: assert property ( // [RL7]
    (ctrl.watchdog_enable && !ctrl.turn_off_enable) |=> ctrl.watchdog_enable
  ) else $error("watchdog disabled outside the turn-off window");

  chk_enable_off: assert property ( // [RL7]
    (wr_ctrl && !wr_data[wdt_pkg::BIT_WATCHDOG_ENABLE] && ctrl.turn_off_enable)
      |=> !ctrl.watchdog_enable
  ) else $error("disable write inside window ignored");

  chk_reserved_zero: assert property ( // [RL5]
    (ar_fire && s_axi_araddr[wdt_pkg::ADDR_W-1:2] == wdt_pkg::OFF_CONTROL[11:2])
      |=> s_axi_rvalid && s_axi_rdata[31:5] == '0
  ) else $error("reserved control bits read non-zero");

  chk_reset_hold: assert property ( // [RL3]
    cnt_state.timeout |=> chip_reset [*8] ##1 (!chip_reset || $past(cnt_state.timeout))
  ) else $error("chip reset not held for its full length");

  chk_no_reset_off: assert property ( // [RL6]
    (!ctrl.watchdog_enable && !chip_reset) |=> !chip_reset
  ) else $error("chip reset raised while watchdog disabled");

  chk_enable_set: assert property ( // [RL6]
    (wr_ctrl && wr_data[wdt_pkg::BIT_WATCHDOG_ENABLE]) |=> ctrl.watchdog_enable
  ) else $error("enable write did not turn the watchdog on");

  chk_reset_quiet: assert property ( // [RL3]
    (!chip_reset && !cnt_state.timeout) |=> !chip_reset
  ) else $error("chip reset raised without a time-out");

  chk_seen_sticky: assert property ( // [RL3]
    cnt_state.timeout |=> reset_seen
  ) else $error("time-out not recorded in status");

  chk_restart_zero: assert property ( // [RL2]
    watchdog_restart_instr |=> cnt_state.count == '0
  ) else $error("restart did not clear the counter");

  chk_restart_reg: assert property ( // [RL2]
    (wr_restart && wr_data[wdt_pkg::BIT_RESTART]) |=> cnt_state.count == '0
  ) else $error("restart register write did not clear the counter");

  chk_count_hold: assert property ( // [RL12]
    (!ctrl.watchdog_enable && !restart_any) |=> $stable(cnt_state.count)
  ) else $error("counter moved while disabled");

  chk_write_answer: assert property (
    do_write |=> s_axi_bvalid
  ) else $error("write response missing");

  chk_read_answer: assert property (
    ar_fire |=> s_axi_rvalid
  ) else $error("read response missing");

  cov_timeout: cover property (cnt_state.timeout ##1 chip_reset);
  cov_disable: cover property (
    (wr_ctrl && ctrl.turn_off_enable) ##1 !ctrl.watchdog_enable
  );
  cov_restart: cover property (ctrl.watchdog_enable && watchdog_restart_instr);

endmodule : wdt_watchdog_reset_timer
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the watchdog reset timer over its register bus.
// Assumes: Inputs change by non-blocking assignment just after core_clk rises.
// Notes: BASE_CYCLES is shrunk to 4 so that all eight time-outs fit in one short run.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int BASE = 4;
  localparam int OSC_HALF = 4; // Core cycles per half oscillator period
  localparam logic [11:0] CTRL = wdt_pkg::OFF_CONTROL;
  localparam logic [11:0] STAT = wdt_pkg::OFF_STATUS;
  localparam logic [11:0] RSTR = wdt_pkg::OFF_RESTART;
  localparam logic [11:0] CNT = wdt_pkg::OFF_COUNT;
  localparam logic [31:0] CTRL_RST = {28'h0, wdt_pkg::RST_ENABLE, wdt_pkg::RST_SEL};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wdt_osc = 1'b0;
  logic osc_run = 1'b0;
  logic restart = 1'b0;
  logic chip_reset;
  logic [wdt_pkg::ADDR_W-1:0] awaddr = '0;
  logic [wdt_pkg::ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, cnt_before;
  int failures = 0;
  int total_checks = 0;
  int rst_cycles = 0;
  int osc_cnt = 0;
  int base_rst;

  wdt_watchdog_reset_timer #(.BASE_CYCLES(BASE)) i_wdt_watchdog_reset_timer (
    .core_clk(core_clk), .rst_n(rst_n), .wdt_osc(wdt_osc),
    .watchdog_restart_instr(restart), .chip_reset(chip_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock, 50 MHz
  always #10 core_clk = ~core_clk;

  // Slow oscillator stand-in; it can be stopped to show the core clock alone never expires
  always @(posedge core_clk) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_run && osc_cnt == OSC_HALF - 1) wdt_osc <= ~wdt_osc;
    if (chip_reset === 1'b1) rst_cycles <= rst_cycles + 1; // Cycles spent in chip reset
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Bus tasks; a trailing edge keeps the next call from driving in the same time step
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check("write_handshake", 32'h0, 32'h1);
    if (!done) wrap_up();
    @(posedge core_clk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check("read_handshake", 32'h0, 32'h1);
    if (!done) wrap_up();
    @(posedge core_clk);
  endtask : axi_read

  task automatic pulse_restart;
    restart <= 1'b1;
    @(posedge core_clk);
    restart <= 1'b0;
    @(posedge core_clk);
  endtask : pulse_restart

  // Phase of the oscillator and the input synchroniser blur the figure by about one period
  task automatic expect_timeout(input int n_osc);
    int t;
    int exp;
    t = 0;
    exp = n_osc * 2 * OSC_HALF;
    while (chip_reset !== 1'b1 && t < exp + 40) begin
      @(posedge core_clk);
      t++;
    end
    check("timeout_window", 32'(t >= exp - 10 && t <= exp + 10), 32'h1);
    t = 0;
    while (chip_reset === 1'b1 && t < 40) begin
      @(posedge core_clk);
      t++;
    end
    check("reset_hold", 32'(t), 32'(wdt_pkg::CHIP_RST_CYCLES));
  endtask : expect_timeout

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    axi_read(CTRL);
    check("ctrl_reset", rd, CTRL_RST);
    axi_write(CTRL, 32'h08, 4'hF);
    pulse_restart();
    repeat (300) @(posedge core_clk);
    check("no_osc_no_reset", 32'(rst_cycles), 32'h0);
    osc_run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      axi_write(CTRL, 32'(8 + s), 4'hF);
      pulse_restart();
      expect_timeout(BASE << s);
    end
    axi_read(STAT);
    check("status_seen", rd & 32'h1, 32'h1);
    axi_write(STAT, 32'h1, 4'hF);
    axi_read(STAT);
    check("status_cleared", rd & 32'h3, 32'h0);
    // Restarts by pulse and by register keep the shortest period from expiring
    pulse_restart();
    axi_write(CTRL, 32'h08, 4'hF);
    base_rst = rst_cycles;
    for (int k = 0; k < 12; k++) begin
      repeat (10) @(posedge core_clk);
      if (k % 2 == 0) pulse_restart();
      else axi_write(RSTR, 32'h1, 4'hF);
    end
    check("restart_holds_off", 32'(rst_cycles), 32'(base_rst));
    // Reserved bits, self-clearing turn-off flag, refused clears
    axi_write(CTRL, 32'hFF, 4'hF);
    repeat (8) @(posedge core_clk);
    axi_read(CTRL);
    check("ctrl_fields", rd, 32'h0F);
    axi_write(CTRL, 32'h07, 4'hF);
    axi_read(CTRL);
    check("clear_refused", rd, 32'h0F);
    axi_write(CTRL, 32'h1F, 4'hF);
    repeat (8) @(posedge core_clk);
    axi_write(CTRL, 32'h07, 4'hF);
    axi_read(CTRL);
    check("late_clear_refused", rd, 32'h0F);
    // Combined write then prompt clear turns the watchdog off
    axi_write(CTRL, 32'h1F, 4'hF);
    axi_write(CTRL, 32'h07, 4'hF);
    axi_read(CTRL);
    check("turn_off", rd, 32'h07);
    axi_write(CTRL, 32'h00, 4'hF);
    axi_read(CNT);
    cnt_before = rd;
    base_rst = rst_cycles;
    repeat (300) @(posedge core_clk);
    check("disabled_no_reset", 32'(rst_cycles), 32'(base_rst));
    axi_read(CNT);
    check("disabled_count_holds", rd, cnt_before);
    // Empty strobe and unmapped places
    axi_write(CTRL, 32'h08, 4'h0);
    check("no_strobe_resp", 32'(resp), 32'(wdt_pkg::RESP_OKAY));
    axi_read(CTRL);
    check("no_strobe_ctrl", rd, 32'h00);
    axi_write(12'h010, 32'h08, 4'hF);
    check("unmapped_wr", 32'(resp), 32'(wdt_pkg::RESP_SLVERR));
    axi_read(12'h010);
    check("unmapped_rd", 32'(resp), 32'(wdt_pkg::RESP_SLVERR));
    // A second reset in mid-run restores the reset values
    axi_write(CTRL, 32'h0F, 4'hF);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    axi_read(CTRL);
    check("ctrl_rereset", rd, CTRL_RST);
    wrap_up();
  end

  // Run limit; running out counts as a mismatch
  initial begin
    repeat (60000) @(posedge core_clk);
    check("run_limit", 32'h0, 32'h1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
